// ### rtl/sbs_defines.vh
`ifndef SBS_DEFINES_VH
`define SBS_DEFINES_VH
// register byte offsets
`define SBS_CTRL_OFF    12'h000
`define SBS_CFG_OFF     12'h004
`define SBS_DLY_OFF     12'h008
`define SBS_FBDLY_OFF   12'h00c
`define SBS_STAT_OFF    12'h010
// ctrl fields (software pulses and mode)
`define SBS_CTRL_MODE_LSB   0
`define SBS_CTRL_START_BIT  2
`define SBS_CTRL_STOP_BIT   3
`define SBS_CTRL_MKEY_BIT   4
`define SBS_CTRL_GKEY_BIT   5
`define SBS_CTRL_ACK_BIT    6
// cfg fields
`define SBS_CFG_MOWN_LSB    0
`define SBS_CFG_GOWN_LSB    2
`define SBS_CFG_CHG_BIT     4
`define SBS_CFG_MFAIL_LSB   8
`define SBS_CFG_AUTOOPEN_BIT 16
`define SBS_CFG_INSTANT_BIT 17
`define SBS_CFG_MSENSE_BIT  18
`define SBS_CFG_RST         32'h0000_0010
// modes
`define SBS_MODE_OFF  2'h0
`define SBS_MODE_MAN  2'h1
`define SBS_MODE_AUTO 2'h2
// ownership codes
`define SBS_OWN_EXT_BIT 1
// timing: system tick period in us and key hold time in ms
`define SBS_TICK_US     1000
`define SBS_CLK_MHZ     200
`define SBS_TICK_CYC    (`SBS_TICK_US * `SBS_CLK_MHZ)
`define SBS_HOLD_MS     5000
`define SBS_HOLD_TICKS  (`SBS_HOLD_MS * 1000 / `SBS_TICK_US)
// engine states
`define SBS_ENG_STOP  2'h0
`define SBS_ENG_CRANK 2'h1
`define SBS_ENG_RUN   2'h2
`endif

// ### rtl/sbs_sequencer.v
// Functional notes
// - start after mains bad for delay, stop after mains good for delay
// - no load discharge before gen breaker opens; discharge acts as trip
// - without mains sensing, mains counts as always bad
// - mains ownership: 0,1 own; 2,3 external
// - gen ownership: 0,1 own; 2,3 external
// - manual mains key toggles mains breaker when owned
// - manual gen key requests gen breaker open or close when owned
// - gen breaker closes only with mains open, never volts both sides
// - mains breaker closes only with gen open, never volts both sides
// - gen feedback blocks mains close while gen not reported open
// - mains opens normally only with engine running to allow gen close
// - manual mode accepts open request for either breaker
// - manual gen close with mains closed opens mains first, if enabled
// - manual mains close with gen closed opens gen first, if enabled
// - gen feedback delay nonzero gives close and open fail warnings
// - mains feedback delay nonzero gives close and open fail warnings
// - mains fail setting nonzero runs gen while mains breaker not closed
// - expected mains auto open suppresses mains close fail in mains loss
// - auto opening instant 0 at gen ready, 1 before engine start
// - mains key held 5 s with engine stopped forces mains open
// - start and stop keys run the engine in manual mode
// - engine start only outside off mode and with no trips
// - gen closes only when running and in tolerance; opening always ok
module sbs_sequencer (
  input  wire        pclk,          // 200 MHz clock
  input  wire        presetn,       // async reset, active low
  input  wire        psel,          // apb select
  input  wire        penable,       // apb enable
  input  wire        pwrite,        // apb direction
  input  wire [11:0] paddr,         // apb byte address
  input  wire [31:0] pwdata,        // apb write data
  output wire        pready,        // apb ready
  output reg  [31:0] prdata,        // apb read data
  output wire        pslverr,       // apb error
  input  wire        mains_ok_pin,  // mains within tolerance
  input  wire        mains_live_pin,// voltage on mains side
  input  wire        gen_ok_pin,    // gen volts and freq in tolerance
  input  wire        gen_live_pin,  // voltage on gen side
  input  wire        mains_fb_pin,  // mains breaker closed contact
  input  wire        gen_fb_pin,    // gen breaker closed contact
  input  wire        trip_pin,      // shutdown, deactivation or discharge
  input  wire        mkey_pin,      // panel mains breaker key
  output reg         mains_coil_q,  // mains breaker close command
  output reg         gen_coil_q,    // gen breaker close command
  output reg         engine_run_q   // engine run command
);
`include "sbs_defines.vh"

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg  [8:0] s1_q;
  reg  [8:0] s2_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= 9'h000;
      s2_q <= 9'h000;
    end
    else
    begin
      s1_q <= {mkey_pin, trip_pin, gen_fb_pin, mains_fb_pin, gen_live_pin,
               gen_ok_pin, mains_live_pin, mains_ok_pin, 1'b0};
      s2_q <= s1_q;
    end
  end
  wire m_ok    = s2_q[1];
  wire m_live  = s2_q[2];
  wire g_ok    = s2_q[3];
  wire g_live  = s2_q[4];
  wire m_fb    = s2_q[5];
  wire g_fb    = s2_q[6];
  wire trip    = s2_q[7]; // discharge already folded in as deactivation
  wire mkey    = s2_q[8];

  //////////////////////////////////////////////////////////////////////////
  // apb registers
  reg  [1:0]  mode_q;
  reg  [31:0] cfg_q;
  reg  [31:0] dly_q;     // [15:0] start delay, [31:16] stop delay, ticks
  reg  [31:0] fbdly_q;   // [15:0] mains fb ticks, [31:16] gen fb ticks
  reg  [3:0]  warn_q;
  wire        wr_en = psel & penable & pwrite;
  wire        wr_ctrl = wr_en & (paddr == `SBS_CTRL_OFF);
  wire        start_key = wr_ctrl & pwdata[`SBS_CTRL_START_BIT];
  wire        stop_key  = wr_ctrl & pwdata[`SBS_CTRL_STOP_BIT];
  wire        mkey_sw   = wr_ctrl & pwdata[`SBS_CTRL_MKEY_BIT];
  wire        gkey_sw   = wr_ctrl & pwdata[`SBS_CTRL_GKEY_BIT];
  wire        ack       = wr_ctrl & pwdata[`SBS_CTRL_ACK_BIT];
  wire        known = (paddr == `SBS_CTRL_OFF) | (paddr == `SBS_CFG_OFF) |
                      (paddr == `SBS_DLY_OFF) | (paddr == `SBS_FBDLY_OFF) |
                      (paddr == `SBS_STAT_OFF);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~known;

  // register writes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q  <= `SBS_MODE_OFF;
      cfg_q   <= `SBS_CFG_RST;
      dly_q   <= 32'h0000_0000;
      fbdly_q <= 32'h0000_0000;
    end
    else if (wr_en)
    begin
      if (paddr == `SBS_CTRL_OFF)
        mode_q <= pwdata[`SBS_CTRL_MODE_LSB +: 2];
      if (paddr == `SBS_CFG_OFF)
        cfg_q <= pwdata;
      if (paddr == `SBS_DLY_OFF)
        dly_q <= pwdata;
      if (paddr == `SBS_FBDLY_OFF)
        fbdly_q <= pwdata;
    end
  end

  // decoded configuration
  wire man   = (mode_q == `SBS_MODE_MAN);
  wire auto  = (mode_q == `SBS_MODE_AUTO);
  wire m_own = ~cfg_q[`SBS_CFG_MOWN_LSB + `SBS_OWN_EXT_BIT];
  wire g_own = ~cfg_q[`SBS_CFG_GOWN_LSB + `SBS_OWN_EXT_BIT];
  wire chg   = cfg_q[`SBS_CFG_CHG_BIT];
  wire mfail_en = |cfg_q[`SBS_CFG_MFAIL_LSB +: 8];
  wire auto_open = cfg_q[`SBS_CFG_AUTOOPEN_BIT];
  wire instant = cfg_q[`SBS_CFG_INSTANT_BIT];
  wire m_good = cfg_q[`SBS_CFG_MSENSE_BIT] & m_ok;

  //////////////////////////////////////////////////////////////////////////
  // system tick divider
  // divider limit held at the counter's own width
  localparam [17:0] TICK_LAST = `SBS_TICK_CYC - 1;
  reg  [17:0] tdiv_q;
  wire        tick = (tdiv_q == TICK_LAST);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tdiv_q <= 18'h00000;
    else
      tdiv_q <= tick ? 18'h00000 : tdiv_q + 18'h00001;
  end

  //////////////////////////////////////////////////////////////////////////
  // mains status filter with start and stop delays
  reg  [15:0] mcnt_q;
  reg         m_bad_q;    // mains declared out of tolerance
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mcnt_q  <= 16'h0000;
      m_bad_q <= 1'b0;
    end
    else if (m_good == ~m_bad_q)
      mcnt_q <= 16'h0000; // state agrees with declared state: no count
    else if (tick)
    begin
      if (mcnt_q >= (m_bad_q ? dly_q[31:16] : dly_q[15:0]))
      begin
        m_bad_q <= ~m_bad_q;
        mcnt_q  <= 16'h0000;
      end
      else
        mcnt_q <= mcnt_q + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // mains key hold timer
  localparam [12:0] HOLD_LIM = `SBS_HOLD_TICKS;
  reg  [12:0] hold_q;
  wire        hold_done = (hold_q == HOLD_LIM);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_q <= 13'h0000;
    else if (!mkey)
      hold_q <= 13'h0000;
    else if (tick && !hold_done)
      hold_q <= hold_q + 13'h0001;
  end
  reg hold_seen_q;

  //////////////////////////////////////////////////////////////////////////
  // engine sequencing
  reg  [1:0]  eng_q;
  // close-fail warning only keeps the gen running with mains-fail set
  wire        need_auto = auto & (m_bad_q | (mfail_en & (~m_fb | warn_q[0])));
  wire        start_ok = (mode_q != `SBS_MODE_OFF) & ~trip;
  wire        gen_ready = (eng_q == `SBS_ENG_RUN) & g_ok;
  reg         man_run_q;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      man_run_q <= 1'b0;
    else if (!man || stop_key)
      man_run_q <= 1'b0;
    else if (start_key)
      man_run_q <= 1'b1;
  end
  wire        run_req = start_ok & (need_auto | (man & man_run_q));
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eng_q        <= `SBS_ENG_STOP;
      engine_run_q <= 1'b0;
    end
    else
    begin
      case (eng_q)
        `SBS_ENG_STOP:
          if (run_req && !(auto && instant && m_fb && m_own))
          begin
            eng_q        <= `SBS_ENG_CRANK;
            engine_run_q <= 1'b1;
          end
        `SBS_ENG_CRANK:
          if (!run_req)
          begin
            eng_q        <= `SBS_ENG_STOP;
            engine_run_q <= 1'b0;
          end
          else if (g_ok)
            eng_q <= `SBS_ENG_RUN;
        `SBS_ENG_RUN:
          if (!run_req && !gen_coil_q)
          begin
            eng_q        <= `SBS_ENG_STOP;
            engine_run_q <= 1'b0;
          end
        default:
        begin
          eng_q        <= `SBS_ENG_STOP;
          engine_run_q <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // breaker commands and interlocks
  wire g_open_fb = ~g_fb;                 // feedback absent reads as open
  wire mkey_evt  = man & mkey_sw;
  wire gkey_evt  = man & gkey_sw;
  reg  g_pend_q;   // gen close waiting for mains to open
  reg  m_pend_q;   // mains close waiting for gen to open
  wire g_close_ok = ~mains_coil_q & ~m_fb & ~(m_live & g_live) & gen_ready &
                    ~trip;
  wire m_close_ok = ~gen_coil_q & g_open_fb & ~(m_live & g_live);
  // automatic targets
  wire a_gen  = auto & gen_ready & run_req;
  wire a_mopen = auto & ((a_gen) |
                 (instant & m_bad_q & (eng_q == `SBS_ENG_STOP)));
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mains_coil_q <= 1'b0;
      gen_coil_q   <= 1'b0;
      g_pend_q     <= 1'b0;
      m_pend_q     <= 1'b0;
      hold_seen_q  <= 1'b0;
    end
    else
    begin
      hold_seen_q <= hold_done;
      // gen breaker
      if (!g_own)
        gen_coil_q <= 1'b0;
      else if (trip)
        gen_coil_q <= 1'b0;
      else if (gkey_evt && gen_coil_q)
        gen_coil_q <= 1'b0;
      else if (gkey_evt && mains_coil_q && chg && m_own)
        g_pend_q <= 1'b1;
      else if ((gkey_evt || g_pend_q) && g_close_ok)
      begin
        gen_coil_q <= 1'b1;
        g_pend_q   <= 1'b0;
      end
      else if (auto)
        gen_coil_q <= a_gen & g_close_ok | gen_coil_q & a_gen;
      else if (!man)
        gen_coil_q <= 1'b0;
      // mains breaker
      if (!m_own)
        mains_coil_q <= 1'b0;
      else if (mkey && hold_done && !hold_seen_q &&
               eng_q == `SBS_ENG_STOP)
        mains_coil_q <= 1'b0;
      else if (g_pend_q)
        mains_coil_q <= 1'b0;
      else if (mkey_evt && mains_coil_q)
        mains_coil_q <= 1'b0;
      else if (mkey_evt && gen_coil_q && chg && g_own)
      begin
        m_pend_q   <= 1'b1;
        gen_coil_q <= 1'b0;
      end
      else if ((mkey_evt || m_pend_q) && m_close_ok)
      begin
        mains_coil_q <= 1'b1;
        m_pend_q     <= 1'b0;
      end
      else if (auto)
        mains_coil_q <= ~a_mopen & (mains_coil_q | m_close_ok);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // breaker feedback supervision, one generate per breaker
  // index 0 mains, 1 gen; warn bits: close fail, open fail
  wire [1:0] cmd  = {gen_coil_q, mains_coil_q};
  wire [1:0] fbk  = {g_fb, m_fb};
  wire [3:0] wset;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_sup
      reg  [15:0] fcnt_q;
      reg         cmd_q;
      wire [15:0] lim = fbdly_q[16*gi +: 16];
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          fcnt_q <= 16'h0000;
          cmd_q  <= 1'b0;
        end
        else
        begin
          cmd_q <= cmd[gi];
          if (cmd_q != cmd[gi] || fbk[gi] == cmd[gi])
            fcnt_q <= 16'h0000;
          else if (tick && fcnt_q != lim)
            fcnt_q <= fcnt_q + 16'h0001;
        end
      end
      wire expire = (lim != 16'h0000) && (fcnt_q == lim) &&
                    (fbk[gi] != cmd[gi]);
      assign wset[2*gi]   = expire & cmd[gi];
      assign wset[2*gi+1] = expire & ~cmd[gi];
    end
  endgenerate

  // sticky warnings, set wins over acknowledge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      warn_q <= 4'h0;
    else
      warn_q <= (ack ? 4'h0 : warn_q) |
                (wset & {2'b11, 1'b1, ~(auto_open & m_bad_q)});
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux
  always @*
  begin
    case (paddr)
      `SBS_CTRL_OFF:  prdata = {30'h0, mode_q};
      `SBS_CFG_OFF:   prdata = cfg_q;
      `SBS_DLY_OFF:   prdata = dly_q;
      `SBS_FBDLY_OFF: prdata = fbdly_q;
      `SBS_STAT_OFF:  prdata = {20'h0, warn_q, eng_q, m_bad_q, g_pend_q,
                                m_pend_q, engine_run_q, gen_coil_q,
                                mains_coil_q};
      default:        prdata = 32'h0000_0000;
    endcase
  end
endmodule

// ### dv/sbs_breaker_model.sv
module sbs_breaker_model (
  input  logic pclk,           // clock
  input  logic mains_up,       // mains source present
  input  logic mains_coil_q,   // mains close command
  input  logic gen_coil_q,     // gen close command
  input  logic engine_run_q,   // engine run command
  output logic mains_ok_pin,   // mains in tolerance
  output logic mains_live_pin, // mains side voltage
  output logic gen_ok_pin,     // gen in tolerance
  output logic gen_live_pin,   // gen side voltage
  output logic mains_fb_pin,   // mains closed contact
  output logic gen_fb_pin      // gen closed contact
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] m_sr = 3'h0;
  logic [2:0] g_sr = 3'h0;
  logic [3:0] run_cnt = 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  // contacts trail the coils by a travel time; engine needs spin-up
  always @(posedge pclk)
  begin
    m_sr <= {m_sr[1:0], mains_coil_q};
    g_sr <= {g_sr[1:0], gen_coil_q};
    run_cnt <= !engine_run_q ? 4'h0 :
               (run_cnt == 4'h8 ? run_cnt : run_cnt + 4'h1);
  end
  // sensing lines, no voltage on gen side until up to speed
  assign mains_fb_pin = m_sr[2];
  assign gen_fb_pin = g_sr[2];
  assign gen_ok_pin = (run_cnt == 4'h8);
  assign gen_live_pin = gen_ok_pin;
  assign mains_ok_pin = mains_up;
  assign mains_live_pin = mains_up;
endmodule

// ### dv/sbs_sequencer_props.sv
module sbs_sequencer_props (
  input logic        pclk,           // clock
  input logic        presetn,        // async reset low
  input logic        psel,           // apb select
  input logic        penable,        // apb enable
  input logic [11:0] paddr,          // apb address
  input logic        pready,         // apb ready
  input logic        pslverr,        // apb error
  input logic        mains_live_pin, // mains side voltage
  input logic        gen_live_pin,   // gen side voltage
  input logic        gen_fb_pin,     // gen closed contact
  input logic        trip_pin,       // trip input
  input logic        mains_coil_q,   // mains close command
  input logic        gen_coil_q,     // gen close command
  input logic        engine_run_q    // engine run command
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  // held conditions, long enough to pass the input synchronisers
  sequence s_both_live;
    (mains_live_pin && gen_live_pin) [*4];
  endsequence
  sequence s_gen_closed;
    gen_fb_pin [*4];
  endsequence
  sequence s_trip;
    trip_pin [*4];
  endsequence
  property p_coil_mutex;
    !(mains_coil_q && gen_coil_q);
  endproperty
  property p_gen_live_block;
    s_both_live |=> !$rose(gen_coil_q);
  endproperty
  property p_mains_live_block;
    s_both_live |=> !$rose(mains_coil_q);
  endproperty
  property p_gen_fb_block;
    s_gen_closed |=> !$rose(mains_coil_q);
  endproperty
  property p_trip_block;
    s_trip |=> !$rose(engine_run_q);
  endproperty
  property p_gen_needs_run;
    $rose(gen_coil_q) |-> engine_run_q;
  endproperty
  property p_unmapped_err;
    psel && penable && paddr > 12'h010 |-> pslverr && pready;
  endproperty
  property p_mapped_ok;
    psel && penable && paddr[1:0] == 2'h0 && paddr <= 12'h010 |->
      !pslverr && pready;
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_coil_mutex: assert property (p_coil_mutex)
    else $error("both breaker coils closed");
  a_gen_live_block: assert property (p_gen_live_block)
    else $error("gen breaker closed with voltage both sides");
  a_mains_live_block: assert property (p_mains_live_block)
    else $error("mains breaker closed with voltage both sides");
  a_gen_fb_block: assert property (p_gen_fb_block)
    else $error("mains breaker closed while gen reported closed");
  a_trip_block: assert property (p_trip_block)
    else $error("engine started with trip active");
  a_gen_needs_run: assert property (p_gen_needs_run)
    else $error("gen breaker closed with engine stopped");
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (p_mapped_ok)
    else $error("mapped access refused");
endmodule
bind sbs_sequencer sbs_sequencer_props sbs_sequencer_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .mains_live_pin(mains_live_pin), .gen_live_pin(gen_live_pin),
  .gen_fb_pin(gen_fb_pin), .trip_pin(trip_pin),
  .mains_coil_q(mains_coil_q), .gen_coil_q(gen_coil_q),
  .engine_run_q(engine_run_q)
);

// ### dv/standby_breaker_sequencer_tb.sv
`include "sbs_defines.vh"
module standby_breaker_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, trip_pin = 1'b0, mains_up = 1'b1;
  logic        mkey_pin = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, rv, base;
  logic        pready, pslverr, err, mains_coil_q, gen_coil_q, engine_run_q;
  logic        mains_ok_pin, mains_live_pin, gen_ok_pin, gen_live_pin;
  logic        mains_fb_pin, gen_fb_pin;
  int          n_mismatch = 0, cmp_count = 0, seed = 79038, k;
  ////////////////////////////////////////////////////////////////////////////
  sbs_sequencer sbs_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .mains_ok_pin(mains_ok_pin),
    .mains_live_pin(mains_live_pin), .gen_ok_pin(gen_ok_pin),
    .gen_live_pin(gen_live_pin), .mains_fb_pin(mains_fb_pin),
    .gen_fb_pin(gen_fb_pin), .trip_pin(trip_pin), .mkey_pin(mkey_pin),
    .mains_coil_q(mains_coil_q), .gen_coil_q(gen_coil_q),
    .engine_run_q(engine_run_q));
  sbs_breaker_model sbs_breaker_model_inst (
    .pclk(pclk), .mains_up(mains_up), .mains_coil_q(mains_coil_q),
    .gen_coil_q(gen_coil_q), .engine_run_q(engine_run_q),
    .mains_ok_pin(mains_ok_pin), .mains_live_pin(mains_live_pin),
    .gen_ok_pin(gen_ok_pin), .gen_live_pin(gen_live_pin),
    .mains_fb_pin(mains_fb_pin), .gen_fb_pin(gen_fb_pin));
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task key(input int b);
    apb(1'b1, `SBS_CTRL_OFF, {30'h0, `SBS_MODE_MAN} | (32'h1 << b));
  endtask
  function logic outv(input int s);
    return s == 0 ? mains_coil_q : (s == 1 ? gen_coil_q : engine_run_q);
  endfunction
  function logic own_exp(input int o);
    return (o & 2) == 0;
  endfunction
  // bounded wait for an output; a settle time when no change is due
  task await(input int s, input logic v);
    int i;
    i = 0;
    if (v === outv(s)) repeat (60) @(posedge pclk);
    while (outv(s) !== v && i < 300)
    begin
      @(posedge pclk);
      i++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    base = (32'h1 << `SBS_CFG_MSENSE_BIT) | (32'h1 << `SBS_CFG_CHG_BIT);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SBS_CFG_OFF, 32'h0);
    chk(rd, `SBS_CFG_RST);
    apb(1'b0, `SBS_STAT_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    rv = $random(seed);
    apb(1'b1, `SBS_DLY_OFF, rv);
    apb(1'b0, `SBS_DLY_OFF, 32'h0);
    chk(rd, rv);
    apb(1'b1, `SBS_CTRL_OFF, 32'h1 << `SBS_CTRL_START_BIT);
    await(2, 1'b0);
    chk(engine_run_q, 1'b0);
    // enter manual first: keys only act once the mode is already manual
    apb(1'b1, `SBS_CTRL_OFF, {30'h0, `SBS_MODE_MAN});
    trip_pin <= 1'b1;
    key(`SBS_CTRL_START_BIT);
    await(2, 1'b0);
    chk(engine_run_q, 1'b0);
    trip_pin <= 1'b0;
    key(`SBS_CTRL_START_BIT);
    await(2, 1'b1);
    chk(engine_run_q, 1'b1);
    mains_up <= 1'b0;
    repeat (20) @(posedge pclk); // gen up to speed before the key
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, `SBS_CFG_OFF, base | 32'h2 | (k << `SBS_CFG_GOWN_LSB));
      key(`SBS_CTRL_GKEY_BIT);
      await(1, own_exp(k));
      chk(gen_coil_q, own_exp(k));
      key(`SBS_CTRL_GKEY_BIT);
      await(1, 1'b0);
      chk(gen_coil_q, 1'b0);
    end
    key(`SBS_CTRL_STOP_BIT);
    await(2, 1'b0);
    chk(engine_run_q, 1'b0);
    mains_up <= 1'b1;
    for (k = 0; k < 4; k++)
    begin
      apb(1'b1, `SBS_CFG_OFF, base | k);
      key(`SBS_CTRL_MKEY_BIT);
      await(0, own_exp(k));
      chk(mains_coil_q, own_exp(k));
      key(`SBS_CTRL_MKEY_BIT);
      await(0, 1'b0);
      chk(mains_coil_q, 1'b0);
    end
    // gen close request with mains closed changes over
    apb(1'b1, `SBS_CFG_OFF, base);
    key(`SBS_CTRL_MKEY_BIT);
    await(0, 1'b1);
    chk(mains_coil_q, 1'b1);
    key(`SBS_CTRL_START_BIT);
    await(2, 1'b1);
    mains_up <= 1'b0;
    repeat (20) @(posedge pclk);
    key(`SBS_CTRL_GKEY_BIT);
    await(1, 1'b1);
    chk(gen_coil_q, 1'b1);
    chk(mains_coil_q, 1'b0);
    apb(1'b0, `SBS_STAT_OFF, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h6);
    // mains close request with gen closed changes back
    key(`SBS_CTRL_MKEY_BIT);
    await(0, 1'b1);
    chk(mains_coil_q, 1'b1);
    chk(gen_coil_q, 1'b0);
    // short key press with engine stopped leaves mains closed
    key(`SBS_CTRL_STOP_BIT);
    await(2, 1'b0);
    mkey_pin <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(mains_coil_q, 1'b1);
    mkey_pin <= 1'b0;
    give_verdict();
  end
endmodule
